// *** src/wosl_pkg.sv ***
// Summary of operation
// - lock only after the full key is stored
// - latch holds four key bytes, staged first
// - lock when 28 of 32 bits match
// - locked part refuses debug and test entry
// - locked latch ignores every erase or write
// - lock needs stage, commit, then reset
// - lock output sampled only during reset
// - key write only with no flash protection
// - full access continues until next reset
// - latch contents readable over debug port
// - protection cleared only by full erase or power-on reset
// - block operations obey block security level
// - whole memory erase, program, verify supported
package wosl_pkg;

    // key and vote geometry
    localparam int KEY_W = 32;
    localparam int VOTE_MIN = 28;
    localparam int VOTE_CNT_W = 6;

    // key pattern; the value is arbitrary, a real part sets its own
    localparam logic [31:0] KEY_PATTERN = 32'h5A3C96E1;

    // value the nonvolatile cells take on power-on in simulation and on erase
    localparam logic [31:0] CELL_BLANK = 32'h00000000;

    // flash block protection geometry
    localparam int NUM_BLOCKS = 4;
    localparam int BLK_IDX_W = 2;
    localparam int LVL_W = 2;
    localparam int PROT_W = NUM_BLOCKS * LVL_W;

    // protection levels
    localparam logic [1:0] LVL_OPEN = 2'h0;
    localparam logic [1:0] LVL_NO_VERIFY = 2'h2;
    localparam logic [7:0] PROT_RESET = 8'h00;

    // cycles the wrapper vote is given to settle before sampling
    localparam logic [1:0] SETTLE_CYCLES = 2'h2;

    // reset-time sequencing, gray along settle, sample, run
    typedef enum logic [1:0] {
        ST_SETTLE = 2'h0,
        ST_SAMPLE = 2'h1,
        ST_RUN = 2'h3
    } wosl_state_type;

    // memory operation kinds
    typedef enum logic [1:0] {
        OP_ERASE = 2'h0,
        OP_PROGRAM = 2'h1,
        OP_VERIFY = 2'h2
    } wosl_op_type;

    // an open block allows all, a verify is refused from LVL_NO_VERIFY up
    function automatic logic opAllowed(input logic [1:0] lvl, input logic [1:0] op);
        logic ok;
        ok = 1'b0;
        if (lvl == LVL_OPEN) begin
            ok = (op == OP_ERASE) || (op == OP_PROGRAM) || (op == OP_VERIFY);
        end else if (op == OP_VERIFY) begin
            ok = (lvl < LVL_NO_VERIFY);
        end
        return ok;
    endfunction : opAllowed

endpackage : wosl_pkg

// *** src/wosl_latch_cell.sv ***
`timescale 1ns/1ps
`default_nettype none
// once_write_lock_cell: volatile staging word, nonvolatile word, vote output
module wosl_latch_cell (
    input wire logic core_clk,
    input wire logic por_b,
    input wire logic stageWe,
    input wire logic [31:0] stageData,
    input wire logic commitReq,
    input wire logic eraseReq,
    output logic lockOut,
    output logic [31:0] cellData
);

    // all state of the cell
    typedef struct packed {
        logic [31:0] stage;
        logic [31:0] cells;
        logic lock;
    } wosl_cell_type;

    localparam int VOTE_CNT_W_L = wosl_pkg::VOTE_CNT_W;

    wosl_cell_type cur_ff;
    wosl_cell_type nxt_cur;
    logic [VOTE_CNT_W_L-1:0] matchCnt; // bits agreeing with the pattern

    // count matching bits; a few failed cells must not drop the lock
    always_comb begin
        matchCnt = '0;
        for (int i = 0; i < wosl_pkg::KEY_W; i++) begin
            matchCnt = matchCnt + VOTE_CNT_W_L'(cur_ff.cells[i] == wosl_pkg::KEY_PATTERN[i]);
        end
    end

    // next state: writes are gated off by the live lock
    always_comb begin
        nxt_cur = cur_ff;
        // 28 of 32 vote
        nxt_cur.lock = (matchCnt >= VOTE_CNT_W_L'(wosl_pkg::VOTE_MIN));
        if (!cur_ff.lock) begin
            if (stageWe) begin
                nxt_cur.stage = stageData; // four bytes staged
            end
            if (eraseReq) begin
                nxt_cur.cells = wosl_pkg::CELL_BLANK;
            end else if (commitReq) begin
                nxt_cur.cells = cur_ff.stage; // commit staging copy
            end
        end
    end

    // power-on and an erase clear the cells, a system reset keeps them
    always_ff @(posedge core_clk or negedge por_b) begin
        if (!por_b) begin
            cur_ff <= '{stage: 32'h00000000, cells: wosl_pkg::CELL_BLANK, lock: 1'b0};
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign lockOut = cur_ff.lock;
    assign cellData = cur_ff.cells;

endmodule : wosl_latch_cell
`default_nettype wire

// *** src/wosl_lockout.sv ***
`timescale 1ns/1ps
`default_nettype none
// device security lockout: samples the latch vote at reset and gates access
module wosl_lockout (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic por_b,
    // key handling from the debug port engine
    input wire logic keyStageReq,
    input wire logic [31:0] keyStageData,
    input wire logic keyCommitReq,
    input wire logic latchEraseReq,
    input wire logic latchReadReq,
    // mode entry requests
    input wire logic debugEntryReq,
    input wire logic testEntryReq,
    // flash protection writes
    input wire logic protWriteReq,
    input wire logic [1:0] protWriteIdx,
    input wire logic [1:0] protWriteLvl,
    // single block operation
    input wire logic blockOpReq,
    input wire logic [1:0] blockOpIdx,
    input wire logic [1:0] blockOpKind,
    // whole memory operation
    input wire logic chipOpReq,
    input wire logic [1:0] chipOpKind,
    // answers
    output logic accessEn,
    output logic debugGrant,
    output logic testGrant,
    output logic entryRefused,
    output logic keyAccepted,
    output logic keyRefused,
    output logic latchReadValid,
    output logic [31:0] latchReadData,
    output logic [7:0] protLevels,
    output logic protAny,
    output logic blockGrant,
    output logic blockDeny,
    output logic chipGrant,
    output logic chipDeny
);

    // all state of the controller
    typedef struct packed {
        wosl_pkg::wosl_state_type state;
        logic [1:0] settleCnt;
        logic lockSampled;
        logic accessEn;
        logic debugGrant;
        logic testGrant;
        logic entryRefused;
        logic keyAccepted;
        logic keyRefused;
        logic readValid;
        logic [31:0] readData;
        logic blockGrant;
        logic blockDeny;
        logic chipGrant;
        logic chipDeny;
    } wosl_ctrl_type;

    wosl_ctrl_type cur_ff;
    wosl_ctrl_type nxt_cur;

    // protection levels mirror flash data, so a system reset must not clear them
    logic [7:0] protNv_ff; // per block levels, kept across rst_b
    logic [7:0] nxt_prot; // next value of the levels
    logic protAny_ff; // registered flag: some level is set

    logic latchLock; // live vote of the latch wrapper
    logic [31:0] latchCells; // nonvolatile contents
    logic running; // sampling is done
    logic open; // external access allowed this run
    logic keyOk; // a key touch may go through
    logic keyTouch; // any request to alter the latch
    logic [1:0] blkLvl; // level of the addressed block
    logic stageWe;
    logic commitWe;
    logic eraseWe;

    // the latch wrapper sits on power-on reset so its cells survive rst_b
    wosl_latch_cell u_cell (
        .core_clk(core_clk),
        .por_b(por_b),
        .stageWe(stageWe),
        .stageData(keyStageData),
        .commitReq(commitWe),
        .eraseReq(eraseWe),
        .lockOut(latchLock),
        .cellData(latchCells)
    );

    // access follows the sampled lock only, never the live vote
    assign running = (cur_ff.state == wosl_pkg::ST_RUN);
    assign open = running && !cur_ff.lockSampled;

    // key writes need an open port and no protection at all
    assign keyTouch = keyStageReq || keyCommitReq || latchEraseReq;
    assign keyOk = open && (protNv_ff == wosl_pkg::PROT_RESET) && !latchLock;
    assign stageWe = keyOk && keyStageReq;
    assign commitWe = keyOk && keyCommitReq;
    assign eraseWe = keyOk && latchEraseReq;

    // level of the block named by a block operation
    assign blkLvl = protNv_ff[blockOpIdx*2 +: 2];

    // next state of the controller
    always_comb begin
        nxt_cur = cur_ff;
        nxt_prot = protNv_ff;
        // one-cycle answers drop by default
        nxt_cur.debugGrant = 1'b0;
        nxt_cur.testGrant = 1'b0;
        nxt_cur.entryRefused = 1'b0;
        nxt_cur.keyAccepted = 1'b0;
        nxt_cur.keyRefused = 1'b0;
        nxt_cur.readValid = 1'b0;
        nxt_cur.blockGrant = 1'b0;
        nxt_cur.blockDeny = 1'b0;
        nxt_cur.chipGrant = 1'b0;
        nxt_cur.chipDeny = 1'b0;
        case (cur_ff.state)
            // let the wrapper vote settle after the release
            wosl_pkg::ST_SETTLE: begin
                nxt_cur.settleCnt = cur_ff.settleCnt + 2'h1;
                if (cur_ff.settleCnt == wosl_pkg::SETTLE_CYCLES - 2'h1) begin
                    nxt_cur.state = wosl_pkg::ST_SAMPLE;
                end
            end
            // the one and only sample of the vote per reset
            wosl_pkg::ST_SAMPLE: begin
                nxt_cur.lockSampled = latchLock;
                nxt_cur.accessEn = !latchLock;
                nxt_cur.state = wosl_pkg::ST_RUN;
            end
            // normal operation
            wosl_pkg::ST_RUN: begin
                // mode entry is refused once locked
                if (debugEntryReq || testEntryReq) begin
                    nxt_cur.debugGrant = open && debugEntryReq;
                    nxt_cur.testGrant = open && testEntryReq;
                    nxt_cur.entryRefused = !open;
                end
                // key handling; a locked latch keeps its cells and the touch is answered with keyRefused
                if (keyTouch) begin
                    nxt_cur.keyAccepted = keyOk;
                    nxt_cur.keyRefused = !keyOk;
                end
                // identify protected parts: reading stays possible
                if (latchReadReq) begin
                    nxt_cur.readValid = 1'b1;
                    nxt_cur.readData = latchCells;
                end
                // levels may only be raised, lowering needs a full erase
                if (protWriteReq && open) begin
                    if (protWriteLvl >= protNv_ff[protWriteIdx*2 +: 2]) begin
                        nxt_prot[protWriteIdx*2 +: 2] = protWriteLvl;
                    end
                end
                // single block operation checks that block's level
                if (blockOpReq) begin
                    if (open && wosl_pkg::opAllowed(blkLvl, blockOpKind)) begin
                        nxt_cur.blockGrant = 1'b1;
                    end else begin
                        nxt_cur.blockDeny = 1'b1;
                    end
                end
                // whole memory operation, refused only when locked
                if (chipOpReq) begin
                    if (open) begin
                        nxt_cur.chipGrant = 1'b1;
                        // a full erase, like power-on reset, returns every level to open
                        if (chipOpKind == wosl_pkg::OP_ERASE) begin
                            nxt_prot = wosl_pkg::PROT_RESET;
                        end
                    end else begin
                        nxt_cur.chipDeny = 1'b1;
                    end
                end
            end
            // unknown code: fall back to sampling again, locked meanwhile
            default: begin
                nxt_cur.state = wosl_pkg::ST_SETTLE;
                nxt_cur.settleCnt = 2'h0;
                nxt_cur.lockSampled = 1'b1;
                nxt_cur.accessEn = 1'b0;
            end
        endcase
    end

    // state register; reset leaves the part closed until the sample
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cur_ff <= '{
                state: wosl_pkg::ST_SETTLE,
                settleCnt: 2'h0,
                lockSampled: 1'b1,
                accessEn: 1'b0,
                debugGrant: 1'b0,
                testGrant: 1'b0,
                entryRefused: 1'b0,
                keyAccepted: 1'b0,
                keyRefused: 1'b0,
                readValid: 1'b0,
                readData: 32'h00000000,
                blockGrant: 1'b0,
                blockDeny: 1'b0,
                chipGrant: 1'b0,
                chipDeny: 1'b0
            };
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // protection register; of the two resets only power-on clears it, so locking then resetting keeps it
    always_ff @(posedge core_clk or negedge por_b) begin
        if (!por_b) begin
            protNv_ff <= wosl_pkg::PROT_RESET;
            protAny_ff <= 1'b0;
        end else begin
            protNv_ff <= nxt_prot;
            protAny_ff <= (nxt_prot != wosl_pkg::PROT_RESET);
        end
    end

    // outputs come straight from the state and protection registers
    assign accessEn = cur_ff.accessEn;
    assign debugGrant = cur_ff.debugGrant;
    assign testGrant = cur_ff.testGrant;
    assign entryRefused = cur_ff.entryRefused;
    assign keyAccepted = cur_ff.keyAccepted;
    assign keyRefused = cur_ff.keyRefused;
    assign latchReadValid = cur_ff.readValid;
    assign latchReadData = cur_ff.readData;
    assign protLevels = protNv_ff;
    assign protAny = protAny_ff;
    assign blockGrant = cur_ff.blockGrant;
    assign blockDeny = cur_ff.blockDeny;
    assign chipGrant = cur_ff.chipGrant;
    assign chipDeny = cur_ff.chipDeny;

endmodule : wosl_lockout
`default_nettype wire

// *** dv/wosl_lockout_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
// watches grants against the access state sampled at reset
module wosl_lockout_monitor (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic debugEntryReq,
    input wire logic chipOpReq,
    input wire logic keyStageReq,
    input wire logic keyCommitReq,
    input wire logic latchReadReq,
    input wire logic accessEn,
    input wire logic debugGrant,
    input wire logic testGrant,
    input wire logic keyAccepted,
    input wire logic latchReadValid,
    input wire logic [7:0] protLevels,
    input wire logic chipGrant
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    // key staged, then committed two cycles later as the host paces it, while open
    sequence sKeyLoad;
        accessEn && keyStageReq ##2 keyCommitReq;
    endsequence

    a_open_debug_grant: assert property (accessEn && debugEntryReq |=> debugGrant)
        else $error("debug entry not granted while open");
    a_locked_no_debug: assert property (debugGrant |-> accessEn)
        else $error("debug granted while locked");
    a_locked_no_test: assert property (testGrant |-> accessEn)
        else $error("test granted while locked");
    a_access_held_run: assert property (!$fell(accessEn))
        else $error("access state changed without reset");
    a_key_needs_open: assert property (keyAccepted |-> accessEn && $past(protLevels) == 8'h00)
        else $error("key touch accepted while locked or protected");
    a_load_keeps_access: assert property (sKeyLoad ##1 keyAccepted |-> ##1 accessEn)
        else $error("access lost after key load");
    a_read_answers: assert property (accessEn && latchReadReq |=> latchReadValid)
        else $error("latch read not answered");
    a_chip_op_grant: assert property (accessEn && chipOpReq |=> chipGrant)
        else $error("whole memory operation not granted");
    a_prot_clear_erase: assert property ($changed(protLevels) && protLevels == 8'h00 |-> chipGrant)
        else $error("protection cleared without full erase");
endmodule : wosl_lockout_monitor
`default_nettype wire

// *** dv/wosl_debug_host.sv ***
`timescale 1ns/1ps
`default_nettype none
// debug host: stages and commits keys, writes block protection
module wosl_debug_host (
    input wire logic core_clk,
    output logic keyStageReq,
    output logic [31:0] keyStageData,
    output logic keyCommitReq,
    output logic protWriteReq,
    output logic [1:0] protWriteIdx,
    output logic [1:0] protWriteLvl
);
    initial begin
        keyStageReq = 1'h0;
        keyStageData = 32'h0;
        keyCommitReq = 1'h0;
        protWriteReq = 1'h0;
        protWriteIdx = 2'h0;
        protWriteLvl = 2'h0;
    end

    // data shows the inverse once released, so nothing relies on a stale word
    task automatic stage(input logic [31:0] k);
        @(posedge core_clk);
        keyStageReq <= 1'h1;
        keyStageData <= k;
        @(posedge core_clk);
        keyStageReq <= 1'h0;
        keyStageData <= ~k;
        #1;
    endtask : stage

    task automatic commit();
        @(posedge core_clk);
        keyCommitReq <= 1'h1;
        @(posedge core_clk);
        keyCommitReq <= 1'h0;
        #1;
    endtask : commit

    task automatic prot(input logic [1:0] idx, input logic [1:0] lvl);
        @(posedge core_clk);
        protWriteReq <= 1'h1;
        protWriteIdx <= idx;
        protWriteLvl <= lvl;
        @(posedge core_clk);
        protWriteReq <= 1'h0;
        protWriteIdx <= ~idx;
        #1;
    endtask : prot

    // key first, then protection, reset left to the caller
    task automatic lockPart(input logic [31:0] k, input logic [1:0] idx, input logic [1:0] lvl);
        stage(k);
        commit();
        prot(idx, lvl);
    endtask : lockPart
endmodule : wosl_debug_host
`default_nettype wire

// *** dv/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [31:0] KEY = wosl_pkg::KEY_PATTERN;
    // request bits: debug, test, erase, read, block, chip
    localparam logic [5:0] D = 6'h20, T = 6'h10, E = 6'h08, R = 6'h04, B = 6'h02, C = 6'h01;
    logic core_clk = 1'h0;
    logic rst_b = 1'h0;
    logic por_b = 1'h0;
    logic [5:0] reqs = 6'h00;
    logic [1:0] opIdx = 2'h0;
    logic [1:0] opKind = 2'h0;
    logic keyStageReq, keyCommitReq, protWriteReq;
    logic [31:0] keyStageData, latchReadData;
    logic [1:0] protWriteIdx, protWriteLvl;
    logic accessEn, debugGrant, testGrant, entryRefused, keyAccepted, keyRefused;
    logic latchReadValid, protAny, blockGrant, blockDeny, chipGrant, chipDeny;
    logic [7:0] protLevels;
    int errors = 0;
    int comparisons = 0;

    always #2 core_clk = ~core_clk;

    wosl_debug_host host (.core_clk, .keyStageReq, .keyStageData, .keyCommitReq,
        .protWriteReq, .protWriteIdx, .protWriteLvl);

    wosl_lockout DUT (.core_clk, .rst_b, .por_b, .keyStageReq, .keyStageData, .keyCommitReq,
        .latchEraseReq(reqs[3]), .latchReadReq(reqs[2]), .debugEntryReq(reqs[5]),
        .testEntryReq(reqs[4]), .protWriteReq, .protWriteIdx, .protWriteLvl,
        .blockOpReq(reqs[1]), .blockOpIdx(opIdx), .blockOpKind(opKind), .chipOpReq(reqs[0]),
        .chipOpKind(opKind), .accessEn, .debugGrant, .testGrant, .entryRefused, .keyAccepted,
        .keyRefused, .latchReadValid, .latchReadData, .protLevels, .protAny, .blockGrant,
        .blockDeny, .chipGrant, .chipDeny);

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // one-cycle request, then look at the one-cycle answer
    task automatic fire(input logic [5:0] r, input logic [1:0] i, input logic [1:0] k);
        @(posedge core_clk);
        reqs <= r;
        opIdx <= i;
        opKind <= k;
        @(posedge core_clk);
        reqs <= 6'h00;
        #1;
    endtask : fire

    // rst_b only keeps the cells; the vote is sampled on the third edge after release
    task automatic resetPart();
        @(posedge core_clk);
        rst_b <= 1'h0;
        repeat (12) @(posedge core_clk);
        rst_b <= 1'h1;
        por_b <= 1'h1;
        repeat (4) @(posedge core_clk);
        #1;
    endtask : resetPart

    task automatic t_open();
        fire(D, 2'h0, 2'h0);
        chk("debugGrant", 1, debugGrant);
        fire(T, 2'h0, 2'h0);
        chk("testGrant", 1, testGrant);
        for (int k = 0; k < 3; k++) begin
            fire(C, 2'h0, k[1:0]);
            chk("chipGrant", 1, chipGrant);
        end
        $display("test open done");
    endtask : t_open

    task automatic t_blocks();
        host.prot(2'h1, 2'h1);
        host.prot(2'h2, 2'h2);
        chk("protLevels", 32'h24, protLevels);
        chk("protAny", 1, protAny);
        fire(B, 2'h1, 2'h2);
        chk("blockGrant", 1, blockGrant);
        fire(B, 2'h1, 2'h0);
        chk("blockDeny", 1, blockDeny);
        fire(B, 2'h2, 2'h2);
        chk("blockDeny", 1, blockDeny);
        fire(B, 2'h0, 2'h1);
        chk("blockGrant", 1, blockGrant);
        host.stage(KEY);
        chk("keyRefused", 1, keyRefused);
        host.prot(2'h1, 2'h0);
        chk("protLevels", 32'h24, protLevels);
        fire(C, 2'h0, 2'h0);
        chk("protLevels", 0, protLevels);
        chk("protAny", 0, protAny);
        $display("test blocks done");
    endtask : t_blocks

    // five bits off the pattern is one short of the vote
    task automatic t_miss();
        host.stage(KEY ^ 32'h1F);
        host.commit();
        chk("keyAccepted", 1, keyAccepted);
        resetPart();
        chk("accessEn", 1, accessEn);
        fire(R, 2'h0, 2'h0);
        chk("latchReadValid", 1, latchReadValid);
        chk("latchReadData", KEY ^ 32'h1F, latchReadData);
        fire(E, 2'h0, 2'h0);
        fire(R, 2'h0, 2'h0);
        chk("latchReadData", 0, latchReadData);
        $display("test miss done");
    endtask : t_miss

    // four bits off still locks, but only after a reset
    task automatic t_lock();
        host.lockPart(KEY ^ 32'h0F, 2'h0, 2'h3);
        chk("accessEn", 1, accessEn);
        fire(D, 2'h0, 2'h0);
        chk("debugGrant", 1, debugGrant);
        resetPart();
        chk("accessEn", 0, accessEn);
        chk("protLevels", 32'h03, protLevels);
        fire(T, 2'h0, 2'h0);
        chk("entryRefused", 1, entryRefused);
        fire(E, 2'h0, 2'h0);
        chk("keyRefused", 1, keyRefused);
        fire(R, 2'h0, 2'h0);
        chk("latchReadData", KEY ^ 32'h0F, latchReadData);
        fire(C, 2'h0, 2'h0);
        chk("chipDeny", 1, chipDeny);
        fire(B, 2'h1, 2'h2);
        chk("blockDeny", 1, blockDeny);
        $display("test lock done");
    endtask : t_lock

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        resetPart();
        t_open();
        t_blocks();
        t_miss();
        t_lock();
        report_and_stop();
    end

    // the run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge core_clk);
        errors++;
        report_and_stop();
    end
endmodule : tb

bind wosl_lockout wosl_lockout_monitor u_mon (.core_clk, .rst_b, .debugEntryReq, .chipOpReq,
    .keyStageReq, .keyCommitReq, .latchReadReq, .accessEn, .debugGrant, .testGrant,
    .keyAccepted, .latchReadValid, .protLevels, .chipGrant);
`default_nettype wire
